// >>> core/input_signal_allocation_mux.sv
// input signal allocation mux: sequence pins routed to internal functions
// Notes on behaviour
// - codes 0-6 pick pins 13,7-12; 9-F inverted
// - code 7 forces active, 8 forces inactive
// - one pin may feed several functions
// - inhibits active-high 0-6; reset codes 1, 2
// - forward torque limit active-low 0-6; reset 8
// - reverse torque limit same as forward
// - option input 3 active-low; reset code 3
// - option inputs 4-6 only pins 10-12
// - other codes there leave function deasserted
`timescale 1ns/1ps
`include "isam_defs.svh"

module input_signal_allocation_mux (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // sequence input pins, bit 0 is pin 7 up to bit 6 is pin 13
    input wire logic [`ISAM_PIN_COUNT-1:0] ioConnectorPins,
    // setting codes, taken while codeWrite is high
    input wire logic codeWrite,
    input wire isam_pkg::isam_codes_type codesIn,
    // held setting codes
    output isam_pkg::isam_codes_type codesOut,
    // function levels, 1 = active
    output isam_pkg::isam_funcs_type funcs
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [`ISAM_PIN_COUNT-1:0] pinMeta_q;
    logic [`ISAM_PIN_COUNT-1:0] pinSync_q;
    logic [`ISAM_PIN_COUNT-1:0] pinSyncB_q;
    logic [`ISAM_PIN_COUNT-1:0] pinStable_q;
    logic [`ISAM_PIN_COUNT-1:0] pinStable_d;

    // a bit is accepted only when the second and third stages agree
    assign pinStable_d = (pinSync_q & ~(pinSync_q ^ pinSyncB_q))
        | (pinStable_q & (pinSync_q ^ pinSyncB_q));

    // three stages; the first is read only by the second
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pinMeta_q <= '0;
            pinSync_q <= '0;
            pinSyncB_q <= '0;
            pinStable_q <= '0;
        end else begin
            pinMeta_q <= ioConnectorPins;
            pinSync_q <= pinMeta_q;
            pinSyncB_q <= pinSync_q;
            pinStable_q <= pinStable_d;
        end
    end

    // ----------------------------------------
    // setting code store
    // ----------------------------------------
    isam_pkg::isam_codes_type codes_q;
    isam_pkg::isam_codes_type codes_d;

    // write replaces all fields at once; no partial update to keep codes coherent
    assign codes_d = codeWrite ? codesIn : codes_q;
    assign codesOut = codes_q;

    // reset codes give the inhibit polarity software should keep
    always_ff @(posedge clk) begin
        if (!nrst) begin
            codes_q.fwdInhibitSelCode <= `ISAM_RST_FWD_INHIBIT;
            codes_q.revInhibitSelCode <= `ISAM_RST_REV_INHIBIT;
            codes_q.fwdTlimSelCode <= `ISAM_RST_FWD_TLIM;
            codes_q.revTlimSelCode <= `ISAM_RST_REV_TLIM;
            codes_q.optIn3SelCode <= `ISAM_RST_OPT_IN3;
            codes_q.optIn4SelCode <= `ISAM_RST_OPT_IN4;
            codes_q.optIn5SelCode <= `ISAM_RST_OPT_IN5;
            codes_q.optIn6SelCode <= `ISAM_RST_OPT_IN6;
        end else begin
            codes_q <= codes_d;
        end
    end

    // ----------------------------------------
    // function selectors
    // ----------------------------------------
    // run inhibits: high pin is active in the first code group
    isam_func_select #(.LOW_FIRST(1'b0), .RESTRICT(1'b0)) uFwdInhibit (
        .clk(clk),
        .nrst(nrst),
        .selCode(codes_q.fwdInhibitSelCode),
        .pins(pinStable_q),
        .active(funcs.fwdRunInhibit)
    );
    isam_func_select #(.LOW_FIRST(1'b0), .RESTRICT(1'b0)) uRevInhibit (
        .clk(clk),
        .nrst(nrst),
        .selCode(codes_q.revInhibitSelCode),
        .pins(pinStable_q),
        .active(funcs.revRunInhibit)
    );

    // torque limits and option input 3: low pin is active in the first group
    isam_func_select #(.LOW_FIRST(1'b1), .RESTRICT(1'b0)) uFwdTlim (
        .clk(clk),
        .nrst(nrst),
        .selCode(codes_q.fwdTlimSelCode),
        .pins(pinStable_q),
        .active(funcs.fwdExtTorqueLimit)
    );
    isam_func_select #(.LOW_FIRST(1'b1), .RESTRICT(1'b0)) uRevTlim (
        .clk(clk),
        .nrst(nrst),
        .selCode(codes_q.revTlimSelCode),
        .pins(pinStable_q),
        .active(funcs.revExtTorqueLimit)
    );
    isam_func_select #(.LOW_FIRST(1'b1), .RESTRICT(1'b0)) uOptIn3 (
        .clk(clk),
        .nrst(nrst),
        .selCode(codes_q.optIn3SelCode),
        .pins(pinStable_q),
        .active(funcs.optionInput3)
    );

    // option inputs 4-6 reach only pins 10-12, other codes read inactive
    isam_func_select #(.LOW_FIRST(1'b1), .RESTRICT(1'b1)) uOptIn4 (
        .clk(clk),
        .nrst(nrst),
        .selCode(codes_q.optIn4SelCode),
        .pins(pinStable_q),
        .active(funcs.optionInput4)
    );
    isam_func_select #(.LOW_FIRST(1'b1), .RESTRICT(1'b1)) uOptIn5 (
        .clk(clk),
        .nrst(nrst),
        .selCode(codes_q.optIn5SelCode),
        .pins(pinStable_q),
        .active(funcs.optionInput5)
    );
    isam_func_select #(.LOW_FIRST(1'b1), .RESTRICT(1'b1)) uOptIn6 (
        .clk(clk),
        .nrst(nrst),
        .selCode(codes_q.optIn6SelCode),
        .pins(pinStable_q),
        .active(funcs.optionInput6)
    );

endmodule : input_signal_allocation_mux

// >>> core/isam_defs.svh
// constants for the input signal allocation mux
`ifndef ISAM_DEFS_SVH
`define ISAM_DEFS_SVH

// ----------------------------------------
// setting code values
// ----------------------------------------
`define ISAM_CODE_FORCE_ON 4'h7
`define ISAM_CODE_FORCE_OFF 4'h8
`define ISAM_CODE_INV_BASE 4'h9
`define ISAM_CODE_PIN13 4'h0
`define ISAM_CODE_RESTR_LO 4'h4
`define ISAM_CODE_RESTR_HI 4'h6
`define ISAM_CODE_RESTR_INV_LO 4'hd

// ----------------------------------------
// reset codes
// ----------------------------------------
`define ISAM_RST_FWD_INHIBIT 4'h1
`define ISAM_RST_REV_INHIBIT 4'h2
`define ISAM_RST_FWD_TLIM 4'h8
`define ISAM_RST_REV_TLIM 4'h8
`define ISAM_RST_OPT_IN3 4'h3
`define ISAM_RST_OPT_IN4 4'h4
`define ISAM_RST_OPT_IN5 4'h5
`define ISAM_RST_OPT_IN6 4'h6

// ----------------------------------------
// pin vector layout: bit 0 is pin 7 ... bit 6 is pin 13
// ----------------------------------------
`define ISAM_PIN_COUNT 7
`define ISAM_PIN13_IDX 3'h6

`endif

// >>> core/isam_func_select.sv
// one function's source and polarity selection
`timescale 1ns/1ps
`include "isam_defs.svh"

module isam_func_select #(
    parameter bit LOW_FIRST = 1'b0,
    parameter bit RESTRICT = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // setting and filtered pins
    input wire logic [3:0] selCode,
    input wire logic [`ISAM_PIN_COUNT-1:0] pins,
    // function level
    output logic active
);

    // code to pin index: 0 is pin 13, 1..6 are pins 7..12
    function automatic logic [2:0] pinIndex(input logic [3:0] code);
        logic [3:0] base;
        base = (code >= `ISAM_CODE_INV_BASE) ? code - `ISAM_CODE_INV_BASE : code;
        // forced codes read no pin, so any in-range index keeps the read defined
        if ((base == `ISAM_CODE_PIN13) || (base > `ISAM_CODE_RESTR_HI)) begin
            pinIndex = `ISAM_PIN13_IDX;
        end else begin
            pinIndex = 3'(base - 4'h1);
        end
    endfunction : pinIndex

    // decode: forced levels, pin selection and polarity
    wire logic forceOn = (selCode == `ISAM_CODE_FORCE_ON) && !RESTRICT;
    wire logic forceOff = (selCode == `ISAM_CODE_FORCE_OFF);
    wire logic inverted = (selCode >= `ISAM_CODE_INV_BASE);
    wire logic restrOk = ((selCode >= `ISAM_CODE_RESTR_LO) && (selCode <= `ISAM_CODE_RESTR_HI))
        || (selCode >= `ISAM_CODE_RESTR_INV_LO);
    wire logic validPin = !forceOff && !forceOn && (!RESTRICT || restrOk);
    wire logic pinLevel = pins[pinIndex(selCode)];
    // low-first functions count a low pin as active in the first code group
    wire logic polLevel = (inverted ^ LOW_FIRST) ? !pinLevel : pinLevel;
    wire logic activeD = forceOn | (validPin & polLevel);

    // registered level, inactive out of reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            active <= 1'b0;
        end else begin
            active <= activeD;
        end
    end

endmodule : isam_func_select

// >>> core/isam_pkg.sv
// types of the input signal allocation mux
package isam_pkg;

    // one 4-bit setting code per function
    typedef struct packed {
        logic [3:0] fwdInhibitSelCode;
        logic [3:0] revInhibitSelCode;
        logic [3:0] fwdTlimSelCode;
        logic [3:0] revTlimSelCode;
        logic [3:0] optIn3SelCode;
        logic [3:0] optIn4SelCode;
        logic [3:0] optIn5SelCode;
        logic [3:0] optIn6SelCode;
    } isam_codes_type;

    // asserted level of each function, 1 = function active
    typedef struct packed {
        logic fwdRunInhibit;
        logic revRunInhibit;
        logic fwdExtTorqueLimit;
        logic revExtTorqueLimit;
        logic optionInput3;
        logic optionInput4;
        logic optionInput5;
        logic optionInput6;
    } isam_funcs_type;

endpackage : isam_pkg

// >>> testbench/isam_assertions.sv
// checker for the input signal allocation mux
`timescale 1ns/1ps
module isam_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // watched ports
    input wire logic [6:0] ioConnectorPins,
    input wire logic codeWrite,
    input wire isam_pkg::isam_codes_type codesIn,
    input wire isam_pkg::isam_codes_type codesOut,
    input wire isam_pkg::isam_funcs_type funcs
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_store; codeWrite |=> codesOut == $past(codesIn); endproperty
    a_store: assert property (p_store) else $error("code not stored");
    property p_hold; !codeWrite |=> $stable(codesOut); endproperty
    a_hold: assert property (p_hold) else $error("code changed");
    property p_rst; $rose(nrst) |-> codesOut == 32'h1288_3456; endproperty
    a_rst: assert property (p_rst) else $error("reset codes");
    property p_on; codesOut.fwdTlimSelCode == 4'h7 |=> funcs.fwdExtTorqueLimit; endproperty
    a_on: assert property (p_on) else $error("force on");
    property p_bad; codesOut[11:8] inside {[4'h0:4'h3], [4'h7:4'hc]}
        |=> !funcs.optionInput4; endproperty
    a_bad: assert property (p_bad) else $error("invalid code");
    // pin levels need a settled stretch because of the input synchronisers
    property p_inh; (codesOut[31:28] == 4'h1 && $stable(ioConnectorPins[0]))[*7]
        |=> funcs.fwdRunInhibit == $past(ioConnectorPins[0]); endproperty
    a_inh: assert property (p_inh) else $error("inhibit level");
    property p_tl; (codesOut.revTlimSelCode == 4'h9 && $stable(ioConnectorPins[6]))[*7]
        |=> funcs.revExtTorqueLimit == $past(ioConnectorPins[6]); endproperty
    a_tl: assert property (p_tl) else $error("limit level");
    property p_o3; (codesOut.optIn3SelCode == 4'h3 && $stable(ioConnectorPins[2]))[*7]
        |=> funcs.optionInput3 == !$past(ioConnectorPins[2]); endproperty
    a_o3: assert property (p_o3) else $error("low level");
endmodule : isam_assertions
bind input_signal_allocation_mux isam_assertions u_chk (.clk, .nrst, .ioConnectorPins,
    .codeWrite, .codesIn, .codesOut, .funcs);

// >>> testbench/isam_pin_model.sv
// far-side model: host outputs and limit switches on the sequence pins
`timescale 1ns/1ps
module isam_pin_model (
    // clock
    input wire logic clk,
    // contact states wanted, 1 = input on
    input wire logic [6:0] want,
    // sequence pins
    output logic [6:0] pins = 7'h00
);
    // contacts move just after the edge; every pin follows its want bit as is
    always @(posedge clk) begin
        pins <= want;
    end
endmodule : isam_pin_model

// >>> testbench/tb_top.sv
// self-checking bench for the input signal allocation mux
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic codeWrite = 1'b0;
    logic [31:0] codesIn = 32'h0;
    logic [6:0] want = 7'h00;
    logic [6:0] pins;
    isam_pkg::isam_codes_type codesOut;
    isam_pkg::isam_funcs_type funcs;
    int failures = 0;
    int check_count = 0;
    // 250 MHz
    always #2 clk = ~clk;
    isam_pin_model model (.clk(clk), .want(want), .pins(pins));
    input_signal_allocation_mux dut (.clk(clk), .nrst(nrst), .ioConnectorPins(pins),
        .codeWrite(codeWrite), .codesIn(codesIn), .codesOut(codesOut), .funcs(funcs));
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // kind 0 inhibit, 1 limit or input 3, 2 restricted inputs
    function automatic logic lvl(input int kind, input logic [3:0] c, input logic [6:0] p);
        int k;
        k = c % 9;
        if (c == 4'h7) return kind != 2;
        if (c == 4'h8 || (kind == 2 && (k < 4 || k > 6))) return 1'b0;
        return p[k == 0 ? 6 : k - 1] ^ (c > 4'h8) ^ (kind != 0);
    endfunction : lvl
    // write all codes, move the contacts, judge after the synchronisers settle
    task automatic run(input logic [31:0] codes, input logic [6:0] p);
        logic [7:0] e;
        @(posedge clk);
        codeWrite <= 1'b1;
        codesIn <= codes;
        want <= p;
        @(posedge clk);
        codeWrite <= 1'b0;
        repeat (8) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            e[7 - i] = lvl(i < 2 ? 0 : (i < 5 ? 1 : 2), codes[31 - 4 * i -: 4], p);
        end
        #1;
        chk("codes", codesOut, codes);
        chk("funcs", {24'h0, funcs}, {24'h0, e});
    endtask : run
    task automatic t_reset;
        repeat (6) @(posedge clk);
        #1;
        chk("reset codes", codesOut, 32'h1288_3456);
        chk("reset funcs", {24'h0, funcs}, 32'h0f);
    endtask : t_reset
    // every code on every field, one pin feeding all of them
    task automatic t_codes;
        for (int c = 0; c < 16; c++) begin
            run({8{c[3:0]}}, 7'h55);
            run({8{c[3:0]}}, 7'h2a);
        end
    endtask : t_codes
    // back-to-back writes, then inhibits kept at reset polarity, pin 7 shared
    task automatic t_mixed;
        @(posedge clk);
        codeWrite <= 1'b1;
        codesIn <= 32'hffff_ffff;
        run(32'h1179_1d26, 7'h41);
        run(32'h1179_1d26, 7'h3e);
    endtask : t_mixed
    task automatic end_sim;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim
    // about 360 cycles expected; cut off well beyond
    initial begin
        #10000;
        failures++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_codes();
        t_mixed();
        end_sim();
    end
endmodule : tb_top
